// File: dv/bpmc_motor.sv
// Fan motor model that turns phase drive into speed and feedback pulses.
`timescale 1ns/1ps
module bpmc_motor
	import bpmc_pkg::*;
(
	input wire logic pclk,
	input wire bpmc_phase_t phase,
	output logic bemf_zero_cross,
	output logic commutate,
	output logic [7:0] motor_speed,
	output logic [7:0] torque_meas,
	output logic [7:0] resist_meas,
	output logic meas_valid
);
	logic [4:0] tick = 5'h0;
	wire drv = phase.drive_en != 3'h0;
	assign torque_meas = 8'h05;
	assign resist_meas = 8'h21;
	assign bemf_zero_cross = &tick && motor_speed != 8'h0;
	assign commutate = tick == 5'h0f && drv;
	assign meas_valid = bemf_zero_cross && drv;
	initial motor_speed = 8'h0;
	always @(posedge pclk) begin
		tick <= tick + 5'h1;
		if (&tick && drv && motor_speed < 8'h40)
			motor_speed <= motor_speed + 8'h1;
		else if (&tick && !drv && motor_speed != 8'h0)
			motor_speed <= motor_speed - 8'h1;
	end
endmodule

// File: dv/bpmc_top_monitor.sv
// Port checker of the protection and mode control block.
`timescale 1ns/1ps
module bpmc_top_monitor
	import bpmc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pwm_in,
	input wire logic thermal_hot,
	input wire logic supply_below_fall,
	input wire bpmc_phase_t phase,
	input wire logic clamp_low_side_switch,
	input wire logic commutate_adv,
	input wire logic sleeping
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire drv = phase.drive_en != 3'h0;
	AST_ACK_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ack late");
	AST_BAD_ADDR: assert property (pready && paddr > 12'h014 |-> pslverr)
		else $error("no slverr");
	AST_HOT: assert property (thermal_hot [*8] |-> !drv)
		else $error("hot drive");
	AST_UV: assert property (supply_below_fall [*8] |-> !drv)
		else $error("uv drive");
	AST_SLEEP: assert property (sleeping |-> !drv)
		else $error("sleep drive");
	AST_WAKE: assert property (pwm_in [*8] |-> !sleeping)
		else $error("no wake");
	AST_CLAMP: assert property ($fell(drv) && $past(phase.low_on[2])
		&& !thermal_hot && !supply_below_fall |-> clamp_low_side_switch)
		else $error("no clamp");
	AST_ADV: assert property (commutate_adv |=> !commutate_adv)
		else $error("long advance");
	cover property ($rose(sleeping));
	cover property ($rose(clamp_low_side_switch));
	cover property (pready && pslverr);
endmodule

bind bpmc_top bpmc_top_monitor bpmc_top_monitor_i (.*);

// File: dv/bpmc_top_test.sv
// Self-checking bench of the protection and mode control block.
`timescale 1ns/1ps
module bpmc_top_test
	import bpmc_pkg::*;
;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, pwm_in = 1'b1, thermal_hot = 1'b0;
	logic thermal_cool = 1'b1, supply_above_rise = 1'b0;
	logic supply_below_fall = 1'b1, err, m1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] duty_permil = 8'hc8, motor_speed, torque_meas, resist_meas;
	logic pready, pslverr, irq, bemf_zero_cross, meas_valid, commutate;
	logic clamp_low_side_switch, commutate_adv, tach_output, sleeping;
	logic [15:0] applied_amp;
	logic [9:0] current_cap_ma;
	bpmc_phase_t phase;
	int n_fail = 0, checks = 0;
	int n_zc;
	logic [31:0] since = 32'h0;
	wire drv = phase.drive_en != 3'h0;
	bpmc_top #(.SLEEP_CYC(50), .SLEW_CYC(4), .INIT_CYC(16)) bpmc_top_i (.*);
	bpmc_motor bpmc_motor_i (.*);
	// Cycles since the last commutation request, for the advance check.
	always @(posedge pclk)
		since <= commutate ? 32'h0 : since + 32'h1;
	initial begin
		forever #4 pclk = ~pclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic xf(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		cyc(1);
		penable <= 1'b1;
		do cyc(1); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		cyc(1);
	endtask
	task automatic till(input logic on);
		for (int n = 0; n < 500 && drv !== on; n++)
			cyc(1);
	endtask
	task automatic tach_gap(output int n);
		logic t;
		n = 0;
		t = tach_output;
		for (int k = 0; k < 400 && tach_output === t; k++)
			cyc(1);
		t = tach_output;
		for (int k = 0; k < 400 && tach_output === t; k++) begin
			cyc(1);
			n += int'(bemf_zero_cross);
		end
	endtask
	task automatic ck(input string s, input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200us;
		n_fail++;
		report_and_stop();
	end
	initial begin
		cyc(20);
		presetn <= 1'b1;
		cyc(40);
		ck("uv", drv, 1'b0);
		for (int i = 0; i < 8; i++) begin
			xf(1'b1, 12'h000, 32'h20003 | 32'(i) << 6);
			cyc(1);
			ck("cap", current_cap_ma, 32'(i * 125));
		end
		xf(1'b0, 12'h000, 32'h0);
		ck("otp", rd, 32'h201c3);
		xf(1'b0, 12'h018, 32'h0);
		ck("map", err, 1'b1);
		{supply_below_fall, supply_above_rise} <= 2'h1;
		xf(1'b1, 12'h010, 32'hffff);
		till(1'b1);
		ck("run", drv, 1'b1);
		cyc(300);
		xf(1'b1, 12'h010, 32'h0);
		ck("slew", applied_amp != 16'h0, 1'b1);
		xf(1'b0, 12'h010, 32'h0);
		ck("slewapp", rd[31:16] != 16'h0, 1'b1);
		ck("slewbuf", rd[15:0], 16'h0);
		cyc(200);
		ck("bemf", !drv || applied_amp >= motor_speed * 16'h5 - 16'h5,
			1'b1);
		{thermal_cool, thermal_hot} <= 2'h1;
		xf(1'b1, 12'h008, 32'h1e);
		cyc(8);
		ck("hot", drv, 1'b0);
		thermal_hot <= 1'b0;
		cyc(20);
		ck("hys", drv, 1'b0);
		xf(1'b1, 12'h00c, 32'h1);
		m1 = irq;
		xf(1'b1, 12'h00c, 32'h0);
		ck("mask", irq ^ m1, 1'b1);
		thermal_cool <= 1'b1;
		till(1'b1);
		ck("cool", drv, 1'b1);
		tach_gap(n_zc);
		ck("tach2", n_zc, 32'h2);
		xf(1'b1, 12'h008, 32'h1);
		xf(1'b0, 12'h008, 32'h0);
		ck("w1c", rd[0], 1'b0);
		for (int k = 0; k < 100 && commutate !== 1'b1; k++)
			cyc(1);
		duty_permil <= 8'h0e;
		till(1'b0);
		xf(1'b0, 12'h008, 32'h0);
		ck("stby", rd[2], 1'b1);
		for (int k = 0; k < 3000 && commutate_adv !== 1'b1; k++)
			cyc(1);
		ck("adv", since, 32'h9c4);
		duty_permil <= 8'h0f;
		till(1'b1);
		ck("duty", drv, 1'b1);
		cyc(100);
		xf(1'b0, 12'h014, 32'h0);
		ck("meas", rd[15:0], 16'h2105);
		{duty_permil, pwm_in} <= 9'h0;
		cyc(40);
		ck("early", sleeping, 1'b0);
		cyc(40);
		ck("sleep", sleeping, 1'b1);
		pwm_in <= 1'b1;
		cyc(8);
		ck("wake", sleeping, 1'b0);
		xf(1'b0, 12'h014, 32'h0);
		ck("reinit", rd[15:0], 16'h0);
		xf(1'b1, 12'h000, 32'h1c0);
		{duty_permil, pwm_in} <= 9'h191;
		till(1'b1);
		cyc(100);
		for (int k = 0; k < 100 && commutate !== 1'b1; k++)
			cyc(1);
		cyc(1);
		ck("adv0", commutate_adv, 1'b1);
		tach_gap(n_zc);
		ck("tach3", n_zc, 32'h3);
		{duty_permil, pwm_in} <= 9'h1c;
		cyc(100);
		ck("nosleep", sleeping, 1'b0);
		ck("float", phase, 9'h0);
		{duty_permil, pwm_in} <= 9'h191;
		cyc(4);
		ck("resync", drv, 1'b1);
		xf(1'b0, 12'h014, 32'h0);
		ck("kept", rd[15:0], 16'h2105);
		report_and_stop();
	end
endmodule

// File: src/bpmc_cfg.svh
// Constants of the protection and mode control block.
`ifndef BPMC_CFG_SVH
`define BPMC_CFG_SVH
`define BPMC_CLK_MHZ 125
`define BPMC_ADV_STEP_US 20
`define BPMC_ADV_STEP_CYC (`BPMC_ADV_STEP_US * `BPMC_CLK_MHZ)
`define BPMC_ILIM_STEP_MA 125
`define BPMC_STBY_PERMIL 15
`define BPMC_SLEEP_CYC 125000
`define BPMC_SLEW_CYC 256
`define BPMC_INIT_CYC 1024
`define BPMC_A_OTP 12'h000
`define BPMC_A_STAT 12'h004
`define BPMC_A_IRQ 12'h008
`define BPMC_A_MASK 12'h00c
`define BPMC_A_CMD 12'h010
`define BPMC_A_MEAS 12'h014
`define BPMC_TACH_DIV2 2'h1
`define BPMC_TACH_DIV3 2'h2
`endif

// File: src/bpmc_pkg.sv
// Types of the protection and mode control block.
package bpmc_pkg;
	typedef struct packed {
		logic [1:0] min_duty_setting;
		logic sleep_allow;
		logic [3:0] spinup_accel_setting;
		logic [3:0] handoff_threshold;
		logic [2:0] current_cap_setting;
		logic [4:0] advance_angle_code;
		logic tach_divide_option;
	} bpmc_otp_t;
	typedef enum logic [2:0] {
		BPMC_INIT = 3'b000,
		BPMC_RUN = 3'b001,
		BPMC_STBY = 3'b011,
		BPMC_SLEEP = 3'b010
	} bpmc_mode_t;
	typedef struct packed {
		logic [2:0] high_on;
		logic [2:0] low_on;
		logic [2:0] drive_en;
	} bpmc_phase_t;
endpackage

// File: src/bpmc_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module bpmc_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	output logic dout
);
	logic [2:0] stage;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage <= 3'h0;
			dout <= 1'b0;
		end else begin
			stage <= {stage[1:0], din};
			if (stage[1] == stage[2]) begin
				dout <= stage[2];
			end
		end
	end
endmodule

// File: src/bpmc_top.sv
// Protection and operating-mode control with APB registers.
`timescale 1ns/1ps
`include "bpmc_cfg.svh"
module bpmc_top
	import bpmc_pkg::*;
#(
	parameter int SLEEP_CYC = `BPMC_SLEEP_CYC,
	parameter int SLEW_CYC = `BPMC_SLEW_CYC,
	parameter int INIT_CYC = `BPMC_INIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pwm_in,
	input wire logic thermal_hot,
	input wire logic thermal_cool,
	input wire logic supply_above_rise,
	input wire logic supply_below_fall,
	input wire logic bemf_zero_cross,
	input wire logic [7:0] duty_permil,
	input wire logic [7:0] motor_speed,
	input wire logic [7:0] torque_meas,
	input wire logic [7:0] resist_meas,
	input wire logic meas_valid,
	input wire logic commutate,
	output bpmc_phase_t phase,
	output logic clamp_low_side_switch,
	output logic [15:0] applied_amp,
	output logic [9:0] current_cap_ma,
	output logic commutate_adv,
	output logic tach_output,
	output logic sleeping,
	output logic irq
);
	localparam logic [11:0] A_OTP = `BPMC_A_OTP;
	localparam logic [11:0] A_STAT = `BPMC_A_STAT;
	localparam logic [11:0] A_IRQ = `BPMC_A_IRQ;
	localparam logic [11:0] A_MASK = `BPMC_A_MASK;
	localparam logic [11:0] A_CMD = `BPMC_A_CMD;
	localparam logic [11:0] A_MEAS = `BPMC_A_MEAS;
	localparam logic [31:0] ADV_STEP = 32'(`BPMC_ADV_STEP_CYC);
	localparam logic [7:0] STBY_LIM = 8'(`BPMC_STBY_PERMIL);
	localparam logic [9:0] ILIM_STEP = 10'(`BPMC_ILIM_STEP_MA);

	typedef struct packed {
		bpmc_otp_t otp;
		bpmc_mode_t mode;
		logic therm_trip;
		logic uv_lock;
		logic [15:0] cmd_buf;
		logic [15:0] cmd_app;
		logic [31:0] slew_cnt;
		logic [31:0] sleep_cnt;
		logic [31:0] init_cnt;
		logic [7:0] kt;
		logic [7:0] rm;
		logic [31:0] adv_cnt;
		logic adv_busy;
		logic [1:0] tach_cnt;
		logic tach;
		logic clamp;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		bpmc_phase_t phase;
		logic [15:0] amp;
		logic [9:0] cap;
		logic adv_pulse;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} bpmc_state_t;

	bpmc_state_t s;
	bpmc_state_t next_s;
	logic pwm_s;
	logic hot_s;
	logic cool_s;
	logic rise_s;
	logic fall_s;
	logic [15:0] bemf;
	logic driving;
	logic gate;
	logic wr;
	logic rd;
	logic [4:0] ev;

	bpmc_sync u_pwm (.pclk(pclk), .presetn(presetn), .din(pwm_in),
		.dout(pwm_s));
	bpmc_sync u_hot (.pclk(pclk), .presetn(presetn), .din(thermal_hot),
		.dout(hot_s));
	bpmc_sync u_cool (.pclk(pclk), .presetn(presetn), .din(thermal_cool),
		.dout(cool_s));
	bpmc_sync u_rise (.pclk(pclk), .presetn(presetn),
		.din(supply_above_rise), .dout(rise_s));
	bpmc_sync u_fall (.pclk(pclk), .presetn(presetn),
		.din(supply_below_fall), .dout(fall_s));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_s = s;
		bemf = 16'(s.kt * motor_speed);
		gate = s.therm_trip || s.uv_lock;
		driving = (s.mode == BPMC_RUN) && !gate;
		// A write lands only at the edge that completes the access phase.
		wr = psel && penable && pwrite && s.pready;
		rd = psel && !penable && !pwrite;
		ev = 5'h0;

		// Protection gates with hysteresis.
		if (hot_s) begin
			next_s.therm_trip = 1'b1;
		end else if (cool_s) begin
			next_s.therm_trip = 1'b0;
		end
		if (fall_s) begin
			next_s.uv_lock = 1'b1;
		end else if (rise_s) begin
			next_s.uv_lock = 1'b0;
		end
		ev[0] = next_s.therm_trip && !s.therm_trip;
		ev[1] = next_s.uv_lock && !s.uv_lock;

		// Speed command slew limiting.
		if (s.slew_cnt != 32'h0) begin
			next_s.slew_cnt = s.slew_cnt - 32'h1;
		end else begin
			next_s.slew_cnt = 32'(SLEW_CYC - 1);
			if (s.cmd_app < s.cmd_buf) begin
				next_s.cmd_app = s.cmd_app + 16'h1;
			end else if (s.cmd_app > s.cmd_buf) begin
				next_s.cmd_app = s.cmd_app - 16'h1;
			end
		end

		// Mode sequencing.
		next_s.sleep_cnt = pwm_s ? 32'h0 : s.sleep_cnt + 32'h1;
		unique case (s.mode)
			BPMC_INIT: begin
				next_s.kt = 8'h0;
				next_s.rm = 8'h0;
				next_s.init_cnt = s.init_cnt + 32'h1;
				if (s.init_cnt >= 32'(INIT_CYC - 1) && !gate) begin
					next_s.mode = BPMC_RUN;
					next_s.init_cnt = 32'h0;
				end
			end
			BPMC_RUN: begin
				if (meas_valid) begin
					next_s.kt = torque_meas;
					next_s.rm = resist_meas;
				end
				if (duty_permil < STBY_LIM) begin
					next_s.mode = BPMC_STBY;
					ev[2] = 1'b1;
				end
			end
			BPMC_STBY: begin
				if (s.otp.sleep_allow &&
						s.sleep_cnt >= 32'(SLEEP_CYC - 1)) begin
					next_s.mode = BPMC_SLEEP;
					ev[3] = 1'b1;
				end else if (duty_permil >= STBY_LIM) begin
					// With sleep_allow clear, kept measurements allow resynchronizing a spinning rotor; with it set, INIT clears them.
					next_s.mode = s.otp.sleep_allow ? BPMC_INIT : BPMC_RUN;
				end
			end
			BPMC_SLEEP: begin
				if (pwm_s) begin
					next_s.mode = BPMC_INIT;
					next_s.init_cnt = 32'h0;
					ev[4] = 1'b1;
				end
			end
		endcase

		// Phase drive with surge clamp on stop.
		// The clamp stays off while a protection gate floats the outputs.
		next_s.clamp = s.phase.drive_en != 3'h0 && !driving && !gate &&
			s.phase.low_on[2];
		if (driving) begin
			next_s.phase.drive_en = 3'h7;
			next_s.phase.high_on = 3'h1;
			next_s.phase.low_on = 3'h4;
		end else begin
			next_s.phase = '0;
			next_s.phase.low_on[2] = next_s.clamp && !gate;
		end
		next_s.amp = (s.cmd_app > bemf) ? s.cmd_app : bemf + 16'h1;
		next_s.cap = 10'(s.otp.current_cap_setting * ILIM_STEP);

		// Advance delay and tach divider.
		next_s.adv_pulse = 1'b0;
		if (commutate && driving) begin
			if (s.otp.advance_angle_code == 5'h0) begin
				next_s.adv_pulse = 1'b1;
			end else begin
				next_s.adv_busy = 1'b1;
				next_s.adv_cnt = 32'(s.otp.advance_angle_code * ADV_STEP);
			end
		end else if (s.adv_busy) begin
			next_s.adv_cnt = s.adv_cnt - 32'h1;
			if (s.adv_cnt == 32'h1) begin
				next_s.adv_busy = 1'b0;
				next_s.adv_pulse = 1'b1;
			end
		end
		if (bemf_zero_cross && driving) begin
			if (s.tach_cnt >= (s.otp.tach_divide_option ?
					`BPMC_TACH_DIV2 : `BPMC_TACH_DIV3)) begin
				next_s.tach_cnt = 2'h0;
				next_s.tach = !s.tach;
			end else begin
				next_s.tach_cnt = s.tach_cnt + 2'h1;
			end
		end

		// APB register access; hardware set wins over clear.
		next_s.pready = psel && penable && !s.pready;
		next_s.pslverr = 1'b0;
		if (psel && !penable) begin
			next_s.pslverr = paddr > A_MEAS || paddr[1:0] != 2'h0;
		end else begin
			next_s.pslverr = s.pslverr && psel;
		end
		if (rd) begin
			unique case (paddr)
				A_OTP: next_s.prdata = 32'(s.otp);
				A_STAT: next_s.prdata = {24'h0, s.mode, sleeping,
					s.clamp, s.uv_lock, s.therm_trip, s.adv_busy};
				A_IRQ: next_s.prdata = {27'h0, s.irq_stat};
				A_MASK: next_s.prdata = {27'h0, s.irq_mask};
				A_CMD: next_s.prdata = {s.cmd_app, s.cmd_buf};
				A_MEAS: next_s.prdata = {16'h0, s.rm, s.kt};
				default: next_s.prdata = 32'h0;
			endcase
		end
		if (wr) begin
			unique case (paddr)
				A_OTP: next_s.otp = bpmc_otp_t'(pwdata[19:0]);
				A_IRQ: next_s.irq_stat = s.irq_stat & ~pwdata[4:0];
				A_MASK: next_s.irq_mask = pwdata[4:0];
				A_CMD: next_s.cmd_buf = pwdata[15:0];
				default: ;
			endcase
		end
		next_s.irq_stat = next_s.irq_stat | ev;
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.uv_lock <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign phase = s.phase;
	assign clamp_low_side_switch = s.clamp;
	assign applied_amp = s.amp;
	assign current_cap_ma = s.cap;
	assign commutate_adv = s.adv_pulse;
	assign tach_output = s.tach;
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleeping <= 1'b0;
			irq <= 1'b0;
		end else begin
			sleeping <= next_s.mode == BPMC_SLEEP;
			irq <= (next_s.irq_stat & next_s.irq_mask) != 5'h0;
		end
	end
endmodule
